// [src/emc_nv_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// RULE_01 - store holds 32 words of 14 bits
// RULE_02 - erase whole 16-word pages, read single words
// RULE_03 - software erases page before programming it
// RULE_04 - write one word, or aligned four-word unit
// RULE_05 - erase page picked by address bit 4 only
// RULE_06 - address bits 4..0 kept, 7..5 read zero
// RULE_07 - data split low 8, high 6 bits
// RULE_08 - four-pair variant has four data pairs
// RULE_09 - time select: 2, 4, 8, 16 ms
// RULE_10 - erase blocked while erase enable clear
// RULE_11 - erase end clears erase enable and start
// RULE_12 - erase start ignored without erase enable
// RULE_13 - erase start reads one while erasing
// RULE_14 - write blocked while write enable clear
// RULE_15 - write end clears write enable and start
// RULE_16 - write start launches write, reads busy
// RULE_17 - write start ignored without write enable
// RULE_18 - read start with read enable reads word
// RULE_19 - enable then start on consecutive cycles
// RULE_20 - cpu stalled for whole operation
// RULE_21 - counter times erase and write cycles
// RULE_22 - new starts ignored while operation runs
module emc_nv_ctrl
  import emc_pkg::*;
#(
  parameter int FOUR_PAIR = 0,
  parameter int EW_BASE_CYCLES = EMC_EW_BASE_CYCLES
)
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic cpu_stall_o
);

  localparam int PAIRS = (FOUR_PAIR != 0) ? EMC_UNIT_WORDS : 1;

  emc_state_t state_r;
  logic [4:0] addr_r;
  logic [7:0] data_lo_r [PAIRS];
  logic [5:0] data_hi_r [PAIRS];
  logic [1:0] tsel_r;
  logic erase_en_r;
  logic erase_go_r;
  logic write_en_r;
  logic write_go_r;
  logic read_en_r;
  logic read_go_r;
  logic erase_arm_r;
  logic write_arm_r;
  logic [EMC_CNT_W-1:0] cnt_r;
  logic [EMC_WORD_W-1:0] mem_r [EMC_WORDS];
  logic [7:0] rdata_nxt;

  logic busy;
  logic ctrl_wr;
  logic erase_launch;
  logic write_launch;
  logic read_launch;
  logic op_done;
  logic [EMC_CNT_W-1:0] ew_cycles;

  assign busy = (state_r != ST_IDLE);
  assign ctrl_wr = reg_wr_i && !busy && (reg_addr_i == EMC_CONTROL); // see RULE_22
  // start only if enable was set by the write in the cycle before
  assign erase_launch = ctrl_wr && reg_wdata_i[EMC_ERASE_GO] &&
                        erase_en_r && erase_arm_r; // see RULE_12 see RULE_19
  assign write_launch = ctrl_wr && !erase_launch &&
                        reg_wdata_i[EMC_WRITE_GO] &&
                        write_en_r && write_arm_r; // see RULE_17 see RULE_19
  assign read_launch = ctrl_wr && !erase_launch && !write_launch &&
                       reg_wdata_i[EMC_READ_GO] && read_en_r; // see RULE_18
  assign op_done = busy && (cnt_r == EMC_CNT_W'(1));
  // duration taken from the time select written with the start bit
  assign ew_cycles = EMC_CNT_W'(EW_BASE_CYCLES) <<
                     reg_wdata_i[EMC_TSEL_HI:EMC_TSEL_LO]; // see RULE_09

  // operation sequencer
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      state_r <= ST_IDLE;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (erase_launch)
          begin
            state_r <= ST_ERASE; // see RULE_10
          end
          else if (write_launch)
          begin
            state_r <= ST_WRITE; // see RULE_14
          end
          else if (read_launch)
          begin
            state_r <= ST_READ;
          end
        end
        default:
        begin
          if (op_done)
          begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // cycle timer
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      cnt_r <= '0;
    end
    else if (erase_launch || write_launch)
    begin
      cnt_r <= ew_cycles; // see RULE_21
    end
    else if (read_launch)
    begin
      cnt_r <= EMC_CNT_W'(EMC_READ_CYCLES);
    end
    else if (busy)
    begin
      cnt_r <= cnt_r - EMC_CNT_W'(1); // see RULE_21
    end
  end

  // erase arming, one cycle wide
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      erase_arm_r <= 1'b0;
    end
    else
    begin
      erase_arm_r <= ctrl_wr && reg_wdata_i[EMC_ERASE_EN]; // see RULE_19
    end
  end

  // write arming, one cycle wide
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      write_arm_r <= 1'b0;
    end
    else
    begin
      write_arm_r <= ctrl_wr && reg_wdata_i[EMC_WRITE_EN]; // see RULE_19
    end
  end

  // time select field
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      tsel_r <= EMC_TSEL_RESET;
    end
    else if (ctrl_wr)
    begin
      tsel_r <= reg_wdata_i[EMC_TSEL_HI:EMC_TSEL_LO]; // see RULE_09
    end
  end

  // erase enable and start bits
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      erase_en_r <= 1'b0;
      erase_go_r <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      erase_en_r <= reg_wdata_i[EMC_ERASE_EN];
      erase_go_r <= erase_launch; // see RULE_13
    end
    else if (op_done && state_r == ST_ERASE)
    begin
      erase_en_r <= 1'b0; // see RULE_11
      erase_go_r <= 1'b0; // see RULE_11
    end
  end

  // write enable and start bits
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      write_en_r <= 1'b0;
      write_go_r <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      write_en_r <= reg_wdata_i[EMC_WRITE_EN];
      write_go_r <= write_launch; // see RULE_16
    end
    else if (op_done && state_r == ST_WRITE)
    begin
      write_en_r <= 1'b0; // see RULE_15
      write_go_r <= 1'b0; // see RULE_15
    end
  end

  // read enable and start bits
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      read_en_r <= 1'b0;
      read_go_r <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      read_en_r <= reg_wdata_i[EMC_READ_EN];
      read_go_r <= read_launch; // see RULE_18
    end
    else if (op_done && state_r == ST_READ)
    begin
      read_go_r <= 1'b0; // see RULE_18
    end
  end

  // address register
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      addr_r <= EMC_ADDR_RESET; // see RULE_06
    end
    else if (reg_wr_i && !busy && reg_addr_i == EMC_ADDR_REG)
    begin
      addr_r <= reg_wdata_i[4:0]; // see RULE_06
    end
  end

  // data register pairs
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      for (int i = 0; i < PAIRS; i++)
      begin
        data_lo_r[i] <= EMC_REG_RESET; // see RULE_07
        data_hi_r[i] <= EMC_REG_RESET[5:0];
      end
    end
    else if (op_done && state_r == ST_READ)
    begin
      data_lo_r[0] <= mem_r[addr_r][7:0];
      data_hi_r[0] <= mem_r[addr_r][13:8];
    end
    else if (reg_wr_i && !busy)
    begin
      for (int i = 0; i < PAIRS; i++)
      begin
        if (reg_addr_i == pair_low(i))
        begin
          data_lo_r[i] <= reg_wdata_i; // see RULE_07
        end
        else if (reg_addr_i == pair_low(i) + 8'h01)
        begin
          data_hi_r[i] <= reg_wdata_i[5:0]; // see RULE_07
        end
      end
    end
  end

  // offset of a pair's low register; four-pair variant uses its own block
  function automatic logic [7:0] pair_low(input int idx);
    logic [7:0] base;
    base = (FOUR_PAIR != 0) ? EMC_DATA0_LOW : EMC_DATA_LOW;
    pair_low = base + 8'(2 * idx); // see RULE_08
  endfunction

  // storage array, deliberately not reset: contents are non-volatile
  always_ff @(posedge clock_i)
  begin
    if (op_done && state_r == ST_ERASE)
    begin
      for (int j = 0; j < EMC_PAGE_WORDS; j++)
      begin
        mem_r[{addr_r[4], 4'(j)}] <= '0; // see RULE_02 see RULE_05
      end
    end
    else if (op_done && state_r == ST_WRITE)
    begin
      if (FOUR_PAIR != 0)
      begin
        for (int k = 0; k < PAIRS; k++)
        begin
          mem_r[{addr_r[4:2], 2'(k)}] <=
            {data_hi_r[k], data_lo_r[k]}; // see RULE_04
        end
      end
      else
      begin
        mem_r[addr_r] <= {data_hi_r[0], data_lo_r[0]}; // see RULE_04 see RULE_01
      end
    end
  end

  // read data multiplexer
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (reg_addr_i == EMC_ADDR_REG)
    begin
      rdata_nxt = {3'h0, addr_r}; // see RULE_06
    end
    else if (reg_addr_i == EMC_CONTROL)
    begin
      rdata_nxt = {tsel_r, erase_en_r, erase_go_r,
                   write_en_r, write_go_r, read_en_r, read_go_r};
    end
    else
    begin
      for (int i = 0; i < PAIRS; i++)
      begin
        if (reg_addr_i == pair_low(i))
        begin
          rdata_nxt = data_lo_r[i];
        end
        else if (reg_addr_i == pair_low(i) + 8'h01)
        begin
          rdata_nxt = {2'h0, data_hi_r[i]}; // see RULE_07
        end
      end
    end
  end

  // read data stands one cycle only
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else
    begin
      reg_rdata_o <= reg_rd_i ? rdata_nxt : 8'h00;
    end
  end

  // stall from launch to completion
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      cpu_stall_o <= 1'b0;
    end
    else if (erase_launch || write_launch || read_launch)
    begin
      cpu_stall_o <= 1'b1; // see RULE_20
    end
    else if (op_done)
    begin
      cpu_stall_o <= 1'b0; // see RULE_20
    end
  end

endmodule
`default_nettype wire

// [src/emc_pkg.sv]
package emc_pkg;

  // register indices on the plain register port
  localparam logic [7:0] EMC_ADDR_REG = 8'h00;
  localparam logic [7:0] EMC_DATA_LOW = 8'h01;
  localparam logic [7:0] EMC_DATA_HIGH = 8'h02;
  localparam logic [7:0] EMC_DATA0_LOW = 8'h03;
  localparam logic [7:0] EMC_DATA0_HIGH = 8'h04;
  localparam logic [7:0] EMC_DATA1_LOW = 8'h05;
  localparam logic [7:0] EMC_DATA1_HIGH = 8'h06;
  localparam logic [7:0] EMC_DATA2_LOW = 8'h07;
  localparam logic [7:0] EMC_DATA2_HIGH = 8'h08;
  localparam logic [7:0] EMC_DATA3_LOW = 8'h09;
  localparam logic [7:0] EMC_DATA3_HIGH = 8'h0A;
  localparam logic [7:0] EMC_CONTROL = 8'h0B;

  // control register field positions
  localparam int EMC_TSEL_HI = 7;
  localparam int EMC_TSEL_LO = 6;
  localparam int EMC_ERASE_EN = 5;
  localparam int EMC_ERASE_GO = 4;
  localparam int EMC_WRITE_EN = 3;
  localparam int EMC_WRITE_GO = 2;
  localparam int EMC_READ_EN = 1;
  localparam int EMC_READ_GO = 0;

  // reset values
  localparam logic [7:0] EMC_REG_RESET = 8'h00;
  localparam logic [4:0] EMC_ADDR_RESET = 5'h00;
  localparam logic [1:0] EMC_TSEL_RESET = 2'h0;

  // store geometry
  localparam int EMC_WORDS = 32;
  localparam int EMC_WORD_W = 14;
  localparam int EMC_PAGE_WORDS = 16;
  localparam int EMC_UNIT_WORDS = 4;

  // timing: 2 ms base, doubled per step of the time select field
  localparam int EMC_CLK_PERIOD_NS = 40;
  localparam int EMC_EW_BASE_TIME_NS = 2000000;
  localparam int EMC_EW_BASE_CYCLES = EMC_EW_BASE_TIME_NS / EMC_CLK_PERIOD_NS;
  localparam int EMC_READ_TIME_NS = 160;
  localparam int EMC_READ_CYCLES =
    (EMC_READ_TIME_NS + EMC_CLK_PERIOD_NS - 1) / EMC_CLK_PERIOD_NS;
  localparam int EMC_CNT_W = 20;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ERASE,
    ST_WRITE,
    ST_READ
  } emc_state_t;

endpackage

// [verif/emc_nv_ctrl_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module emc_nv_asserts
  import emc_pkg::*;
#(
  parameter int EW_BASE_CYCLES = EMC_EW_BASE_CYCLES
)
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic cpu_stall_o
);
  logic cw, cr, arm_e, arm_w, bsy;
  logic [7:0] d;
  int len_r, exp_r;
  assign d = reg_wdata_i;
  assign bsy = cpu_stall_o;
  assign cw = reg_wr_i && reg_addr_i == EMC_CONTROL;
  assign cr = reg_rd_i && reg_addr_i == EMC_CONTROL;
  assign arm_e = cw && d[5];
  assign arm_w = cw && d[3];
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // cycles spent in the running operation
  always_ff @(posedge clock_i)
    len_r <= (resetn_i && bsy) ? len_r + 1 : 0;
  always_ff @(posedge clock_i)
    if (!resetn_i)
      exp_r <= 0;
    else if (cw && !bsy)
      exp_r <= (d[4] || d[2]) ? EW_BASE_CYCLES << d[7:6]
        : EMC_READ_CYCLES;
  a_op_length:
    assert property ($fell(bsy) |-> len_r == exp_r) else $error("bad length");
  a_no_go_idle:
    assert property (cw && !bsy && (d & 8'h15) == 8'h00 |=> !bsy)
      else $error("stall without start");
  a_erase_unarmed:
    assert property (cw && !bsy && d[4] && !d[2] && !d[0] && !$past(arm_e)
      |=> !bsy) else $error("erase without arm");
  a_write_unarmed:
    assert property (cw && !bsy && d[2] && !d[4] && !d[0] && !$past(arm_w)
      |=> !bsy) else $error("write without arm");
  a_busy_start_bit:
    assert property (bsy && cr ##1 bsy |-> (reg_rdata_o & 8'h15) != 8'h00)
      else $error("start bit low while busy");
  a_idle_start_bit:
    assert property (cr && !bsy |=> (reg_rdata_o & 8'h15) == 8'h00)
      else $error("start bit high while idle");
  a_addr_top_zero:
    assert property (reg_rd_i && reg_addr_i == EMC_ADDR_REG
      |=> reg_rdata_o[7:5] == 3'h0) else $error("address top bits");
  a_high_top_zero:
    assert property (reg_rd_i && reg_addr_i == EMC_DATA_HIGH
      |=> reg_rdata_o[7:6] == 2'h0) else $error("data high top bits");
  c_long_op: cover property ($fell(bsy) && exp_r == EW_BASE_CYCLES << 3);
  c_busy_read: cover property (bsy && cr);
  c_unarmed: cover property (cw && !bsy && d[4] && !$past(arm_e));
endmodule
bind emc_nv_ctrl emc_nv_asserts #(.EW_BASE_CYCLES(EW_BASE_CYCLES)) u_chk (
  .clock_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .cpu_stall_o);
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench
  import emc_pkg::*;
;
  localparam int EW = 8;
  logic clock_i, resetn_i, reg_wr_i, reg_rd_i, cpu_stall_o;
  logic stall4;
  logic got = 1'b0;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rdata4;
  // bit 16 set: four-pair variant is compared too
  logic [16:0] q[$];
  logic [16:0] nt;
  logic [13:0] w;
  logic [13:0] u [4];
  int seed = 55144;
  int miscompares = 0;
  int n_compared = 0;
  emc_nv_ctrl #(.EW_BASE_CYCLES(EW)) dut (.clock_i, .resetn_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .cpu_stall_o);
  // four-pair variant on the same bus; its data registers sit at other indices
  emc_nv_ctrl #(.FOUR_PAIR(1), .EW_BASE_CYCLES(EW)) dut_four (.clock_i,
    .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o(rdata4), .cpu_stall_o(stall4));
  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_wr_i <= 1'b1;
    reg_rd_i <= 1'b0;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_rd_i <= 1'b1;
    reg_wr_i <= 1'b0;
    reg_addr_i <= a;
    q.push_back({1'b0, 8'h00, e});
    @(posedge clock_i);
  endtask
  task automatic rd2(input logic [7:0] a, input logic [7:0] e,
      input logic [7:0] e4);
    reg_rd_i <= 1'b1;
    reg_wr_i <= 1'b0;
    reg_addr_i <= a;
    q.push_back({1'b1, e4, e});
    @(posedge clock_i);
  endtask
  // counts busy cycles still to come
  task automatic wait_op(input int n);
    int c = 0;
    int c4 = 0;
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    for (int i = 0; i < 2000; i++)
    begin
      @(posedge clock_i);
      if (stall4 === 1'b1)
        c4++;
      if (cpu_stall_o !== 1'b1)
        break;
      c++;
    end
    if (c >= 2000)
    begin
      miscompares++;
      finish_test();
    end
    check(16'(c), 16'(n));
    check(16'(c4), 16'(n));
  endtask
  task automatic op(input logic [7:0] en, input logic [7:0] go, input int n);
    wr(EMC_CONTROL, en);
    wr(EMC_CONTROL, go);
    wait_op(n);
  endtask
  task automatic rword(input logic [7:0] a, input logic [13:0] v);
    wr(EMC_ADDR_REG, a);
    op(8'h02, 8'h03, EMC_READ_CYCLES);
    rd(EMC_DATA_LOW, v[7:0]);
    rd(EMC_DATA_HIGH, {2'h0, v[13:8]});
  endtask
  always @(posedge clock_i)
  begin
    if (got)
    begin
      nt = q.pop_front();
      check({8'h00, reg_rdata_o}, {8'h00, nt[7:0]});
      if (nt[16])
        check({8'h00, rdata4}, {8'h00, nt[15:8]});
    end
    got <= reg_rd_i;
  end
  initial
  begin
    resetn_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    for (int a = 0; a < 13; a++)
      rd(8'(a), 8'h00);
    wr(EMC_ADDR_REG, 8'hFF);
    rd(EMC_ADDR_REG, 8'h1F);
    wr(8'h03, 8'h55);
    rd2(8'h03, 8'h00, 8'h55);
    for (int t = 0; t < 4; t++)
    begin
      wr(EMC_ADDR_REG, {3'h0, t[0], 4'h5});
      wr(EMC_CONTROL, {t[1:0], 6'h20});
      wr(EMC_CONTROL, {t[1:0], 6'h30});
      rd(EMC_CONTROL, {t[1:0], 6'h30});
      wr(EMC_ADDR_REG, 8'h0A);
      wait_op((EW << t) - 2);
      rd(EMC_ADDR_REG, {3'h0, t[0], 4'h5});
      rd(EMC_CONTROL, {t[1:0], 6'h00});
      rword({3'h0, t[0], 4'h9}, 14'h0000);
    end
    wr(EMC_CONTROL, 8'h04);
    rd(EMC_CONTROL, 8'h00);
    wr(EMC_CONTROL, 8'h01);
    rd(EMC_CONTROL, 8'h00);
    wr(EMC_CONTROL, 8'h0C);
    rd(EMC_CONTROL, 8'h08);
    wr(EMC_CONTROL, 8'h30);
    rd(EMC_CONTROL, 8'h20);
    // both pages were erased above first
    for (int i = 0; i < 2; i++)
    begin
      w = 14'($random(seed));
      wr(EMC_ADDR_REG, {3'h0, i[0], 4'h3});
      wr(EMC_DATA_LOW, w[7:0]);
      wr(EMC_DATA_HIGH, {2'h3, w[13:8]});
      op(8'h08, 8'h0C, EW);
      rd(EMC_CONTROL, 8'h00);
      rword({3'h0, i[0], 4'h2}, 14'h0000);
      rword({3'h0, i[0], 4'h3}, w);
    end
    // aligned four-word unit; low address bits must be ignored
    wr(EMC_ADDR_REG, 8'h17);
    for (int k = 0; k < 4; k++)
    begin
      u[k] = 14'($random(seed));
      wr(8'(EMC_DATA0_LOW + 2 * k), u[k][7:0]);
      wr(8'(EMC_DATA0_HIGH + 2 * k), {2'h3, u[k][13:8]});
    end
    op(8'h08, 8'h0C, EW);
    for (int k = 0; k < 4; k++)
    begin
      wr(EMC_ADDR_REG, 8'(8'h14 + k));
      op(8'h02, 8'h03, EMC_READ_CYCLES);
      rd2(EMC_DATA0_LOW, 8'h00, u[k][7:0]);
      rd2(EMC_DATA0_HIGH, 8'h00, {2'h0, u[k][13:8]});
    end
    wr(EMC_CONTROL, 8'hE0);
    wr(EMC_CONTROL, 8'hF0);
    resetn_i <= 1'b0;
    reg_wr_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    rd(EMC_CONTROL, 8'h00);
    wait_op(0);
    repeat (2) @(posedge clock_i);
    finish_test();
  end
endmodule
`default_nettype wire
